// ===== verilog/line_brownout_defs.vh
// Offsets, field positions, reset values and timing figures of the line brown-out qualifier
`ifndef LINE_BROWNOUT_DEFS_VH
`define LINE_BROWNOUT_DEFS_VH

// Clock rate and timing figures
`define CLK_KHZ 100000
`define BLANK_MS 50
`define BLANK_MIN_MS 25
`define WINDOW_MS 50
`define STARTUP_DELAY_MS 20
`define BLANK_CYCLES (`BLANK_MS * `CLK_KHZ)
`define BLANK_MIN_CYCLES (`BLANK_MIN_MS * `CLK_KHZ)
`define WINDOW_CYCLES (`WINDOW_MS * `CLK_KHZ)

// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00c

// Control register fields
`define CTRL_FORCE_OFF 0
`define CTRL_RESET 1'h0

// Interrupt event bits
`define EV_BLANK_START 0
`define EV_CONFIRMED 1
`define EV_WINDOW_PASS 2
`define EV_RECOVERED 3
`define EV_WIDTH 4
`define IRQ_MASK_RESET 4'h0

// Qualifier states
`define ST_OFF 3'h0
`define ST_LOW 3'h1
`define ST_RUN 3'h2
`define ST_BLANK 3'h3
`define ST_WINDOW 3'h4

// AHB transfer types
`define HTRANS_NONSEQ 2'h2

`endif

// ===== verilog/interval_timer.v
// Down-counting interval timer with abort and a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
    parameter W = 32
) (
    input wire hclk,
    input wire hresetn,
    input wire start,
    input wire abort,
    input wire [W-1:0] len,
    output reg busy_q,
    output reg done_q
);
    reg [W-1:0] cnt_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= {W{1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
                cnt_q <= {W{1'b0}};
            end else if (start) begin
                busy_q <= 1'b1;
                cnt_q <= len - {{(W-1){1'b0}}, 1'b1};
            end else if (busy_q) begin
                if (cnt_q == {W{1'b0}}) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/line_brownout_qualifier.v
// Line brown-out qualifier with blanking and confirmation timers and an AHB-Lite register slave
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`include "line_brownout_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module line_brownout_qualifier #(
    parameter [31:0] BLANK_CYCLES = `BLANK_CYCLES,
    parameter [31:0] BLANK_MIN_CYCLES = `BLANK_MIN_CYCLES,
    parameter [31:0] WINDOW_CYCLES = `WINDOW_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout_q,
    output reg hresp_q,
    output reg [31:0] hrdata_q,
    output reg irq_q,
    input wire sense_below_threshold,
    input wire supply_lockout,
    input wire remote_off,
    input wire feedback_undervoltage,
    input wire thermal_shutdown,
    input wire supply_start_level,
    output reg brownout_compare_out_q,
    output reg sense_clamp_source_q,
    output reg line_low_flag_q,
    output reg pfc_drive_enable_q,
    output reg ctrl_node_ground_q,
    output reg hysteresis_sink_q,
    output reg sense_pulldown_q,
    output reg latch_clear_q,
    output reg startup_delay_reset_q
);
    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg cmp_q;
    reg blank_start;
    reg window_start;
    reg timer_abort;
    reg confirm;
    reg pass;
    reg recover;
    reg force_off_q;
    reg [`EV_WIDTH-1:0] irq_stat_q;
    reg [`EV_WIDTH-1:0] irq_mask_q;
    reg [`EV_WIDTH-1:0] irq_stat_d;
    reg [`EV_WIDTH-1:0] events;
    reg [`EV_WIDTH-1:0] rd_clear;
    reg wr_pend_q;
    reg [11:0] wr_addr_q;
    reg [31:0] rd_data;
    wire blank_done;
    wire window_done;
    wire off_mode;
    wire addr_phase;
    wire [31:0] blank_len;

    assign off_mode = supply_lockout | remote_off | feedback_undervoltage | thermal_shutdown |
        force_off_q;
    assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
    // The blanking count is held at or above its guaranteed minimum
    assign blank_len = (BLANK_CYCLES < BLANK_MIN_CYCLES) ? BLANK_MIN_CYCLES : BLANK_CYCLES;

    ////////////////////////////////////////////////////////////////////////////////
    // Timers
    interval_timer #(
        .W(32)
    ) u_blank (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(blank_start),
        .abort(timer_abort),
        .len(blank_len),
        .busy_q(),
        .done_q(blank_done)
    );

    interval_timer #(
        .W(32)
    ) u_window (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(window_start),
        .abort(timer_abort),
        .len(WINDOW_CYCLES),
        .busy_q(),
        .done_q(window_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Qualifier state machine
    always @* begin
        st_d = st_q;
        blank_start = 1'b0;
        window_start = 1'b0;
        timer_abort = 1'b0;
        confirm = 1'b0;
        pass = 1'b0;
        recover = 1'b0;
        if (off_mode) begin
            st_d = `ST_OFF;
            timer_abort = 1'b1;
        end else begin
            case (st_q)
                `ST_OFF: begin
                    st_d = `ST_LOW;
                end
                `ST_LOW: begin
                    if (!cmp_q) begin
                        st_d = `ST_RUN;
                        recover = 1'b1;
                    end
                end
                `ST_RUN: begin
                    if (cmp_q) begin
                        st_d = `ST_BLANK;
                        blank_start = 1'b1;
                    end
                end
                `ST_BLANK: begin
                    if (!cmp_q) begin
                        st_d = `ST_RUN;
                        timer_abort = 1'b1;
                    end else if (blank_done) begin
                        st_d = `ST_WINDOW;
                        window_start = 1'b1;
                    end
                end
                `ST_WINDOW: begin
                    if (!cmp_q) begin
                        st_d = `ST_RUN;
                        timer_abort = 1'b1;
                        pass = 1'b1;
                    end else if (window_done) begin
                        st_d = `ST_LOW;
                        confirm = 1'b1;
                    end
                end
                default: begin
                    st_d = `ST_OFF;
                end
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= `ST_OFF;
            cmp_q <= 1'b0;
            brownout_compare_out_q <= 1'b0;
            sense_clamp_source_q <= 1'b0;
            line_low_flag_q <= 1'b1;
            pfc_drive_enable_q <= 1'b0;
            ctrl_node_ground_q <= 1'b1;
            hysteresis_sink_q <= 1'b0;
            sense_pulldown_q <= 1'b1;
            latch_clear_q <= 1'b0;
            startup_delay_reset_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cmp_q <= sense_below_threshold;
            brownout_compare_out_q <= sense_below_threshold;
            // Clamp holds the pin near threshold only while the flag is clear
            sense_clamp_source_q <= sense_below_threshold &&
                (st_d == `ST_RUN || st_d == `ST_BLANK || st_d == `ST_WINDOW);
            line_low_flag_q <= (st_d == `ST_OFF) || (st_d == `ST_LOW);
            pfc_drive_enable_q <= !((st_d == `ST_OFF) || (st_d == `ST_LOW));
            ctrl_node_ground_q <= (st_d == `ST_OFF) || (st_d == `ST_LOW);
            // Sink runs with the flag set, once the supply has reached its start level
            hysteresis_sink_q <= ((st_d == `ST_OFF) || (st_d == `ST_LOW)) &&
                supply_start_level;
            sense_pulldown_q <= (st_d == `ST_OFF);
            latch_clear_q <= confirm;
            startup_delay_reset_q <= recover;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    always @* begin
        events = {`EV_WIDTH{1'b0}};
        events[`EV_BLANK_START] = blank_start;
        events[`EV_CONFIRMED] = confirm;
        events[`EV_WINDOW_PASS] = pass;
        events[`EV_RECOVERED] = recover;
        rd_clear = {`EV_WIDTH{1'b0}};
        if (addr_phase && !hwrite && haddr[11:0] == `OFS_IRQ_STATUS) begin
            rd_clear = {`EV_WIDTH{1'b1}};
        end
        // A new event wins over the read clear
        irq_stat_d = (irq_stat_q & ~rd_clear) | events;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    always @* begin
        rd_data = 32'h00000000;
        case (haddr[11:0])
            `OFS_CTRL: begin
                rd_data[`CTRL_FORCE_OFF] = force_off_q;
            end
            `OFS_STATUS: begin
                rd_data[2:0] = st_q;
                rd_data[3] = cmp_q;
                rd_data[4] = line_low_flag_q;
                rd_data[5] = hysteresis_sink_q;
                rd_data[6] = sense_clamp_source_q;
                rd_data[7] = sense_pulldown_q;
            end
            `OFS_IRQ_STATUS: begin
                rd_data[`EV_WIDTH-1:0] = irq_stat_q;
            end
            `OFS_IRQ_MASK: begin
                rd_data[`EV_WIDTH-1:0] = irq_mask_q;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= 32'h00000000;
            irq_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            force_off_q <= `CTRL_RESET;
            irq_stat_q <= {`EV_WIDTH{1'b0}};
            irq_mask_q <= `IRQ_MASK_RESET;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_mask_q);
            wr_pend_q <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_q <= haddr[11:0];
                if (!hwrite) begin
                    hrdata_q <= rd_data;
                end
            end
            if (wr_pend_q) begin
                if (wr_addr_q == `OFS_CTRL) begin
                    force_off_q <= hwdata[`CTRL_FORCE_OFF];
                end
                if (wr_addr_q == `OFS_IRQ_MASK) begin
                    irq_mask_q <= hwdata[`EV_WIDTH-1:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/sense_divider_model.sv
// Line-sense divider model feeding the brown-out comparator
`timescale 1ns/100ps
`default_nettype none
module sense_divider_model (
    input wire logic [1:0] lvl,
    input wire logic sink,
    input wire logic pull_low,
    output logic below
);
    // Level 2 healthy, 1 marginal (the sink tips it below), 0 collapsed
    assign below = pull_low | (lvl == 2'h0) | (lvl == 2'h1 & sink);
endmodule
`default_nettype wire

// ===== verif/line_brownout_qualifier_asserts.sv
// Port checks for the line brown-out qualifier
`timescale 1ns/100ps
`default_nettype none
module line_brownout_qualifier_asserts #(
    parameter [31:0] BLANK_CYCLES = 32'h14,
    parameter [31:0] BLANK_MIN_CYCLES = 32'ha,
    parameter [31:0] WINDOW_CYCLES = 32'h14
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sense_below_threshold,
    input wire logic supply_lockout,
    input wire logic remote_off,
    input wire logic feedback_undervoltage,
    input wire logic thermal_shutdown,
    input wire logic supply_start_level,
    input wire logic brownout_compare_out_q,
    input wire logic sense_clamp_source_q,
    input wire logic line_low_flag_q,
    input wire logic pfc_drive_enable_q,
    input wire logic ctrl_node_ground_q,
    input wire logic hysteresis_sink_q,
    input wire logic sense_pulldown_q,
    input wire logic latch_clear_q,
    input wire logic startup_delay_reset_q
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Cycles the comparator output has been high without a break
    logic [31:0] hi_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_q <= 32'h0;
        end else if (!brownout_compare_out_q) begin
            hi_q <= 32'h0;
        end else begin
            hi_q <= hi_q + 32'h1;
        end
    end
    cmp_copy_a: assert property ($past(hresetn)
        |-> brownout_compare_out_q == $past(sense_below_threshold))
        else $error("compare output lost the comparator");
    drive_stop_a: assert property (line_low_flag_q && $past(line_low_flag_q)
        |-> !pfc_drive_enable_q && ctrl_node_ground_q) else $error("driver on while line low");
    clamp_off_a: assert property (line_low_flag_q && $past(line_low_flag_q)
        |-> !sense_clamp_source_q) else $error("clamp kept while line low");
    sink_start_a: assert property (!$past(supply_start_level) |-> !hysteresis_sink_q)
        else $error("sink on below start level");
    confirm_len_a: assert property (latch_clear_q
        |-> hi_q >= BLANK_MIN_CYCLES + WINDOW_CYCLES) else $error("fault confirmed too early");
    confirm_flag_a: assert property (latch_clear_q |-> ##[0:1] line_low_flag_q)
        else $error("latch clear without line low");
    off_force_a: assert property (supply_lockout || remote_off || feedback_undervoltage
        || thermal_shutdown |-> ##[1:2] line_low_flag_q && sense_pulldown_q)
        else $error("off condition not forcing line low");
    short_dip_a: assert property ($rose(brownout_compare_out_q) && pfc_drive_enable_q
        |-> pfc_drive_enable_q [*8]) else $error("driver dropped during blanking");
    restart_a: assert property (startup_delay_reset_q |-> ##[0:1] !line_low_flag_q)
        else $error("start-up delay reset without restart");
endmodule
bind line_brownout_qualifier line_brownout_qualifier_asserts #(.BLANK_CYCLES(BLANK_CYCLES),
    .BLANK_MIN_CYCLES(BLANK_MIN_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (.hclk, .hresetn,
    .sense_below_threshold, .supply_lockout, .remote_off, .feedback_undervoltage,
    .thermal_shutdown, .supply_start_level, .brownout_compare_out_q, .sense_clamp_source_q,
    .line_low_flag_q, .pfc_drive_enable_q, .ctrl_node_ground_q, .hysteresis_sink_q,
    .sense_pulldown_q, .latch_clear_q, .startup_delay_reset_q);
`default_nettype wire

// ===== verif/line_brownout_qualifier_tb_top.sv
// Register-level bench for the line brown-out qualifier
`timescale 1ns/100ps
`default_nettype none
module line_brownout_qualifier_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
    logic [1:0] htrans = 2'h0, lvl = 2'h2;
    logic supply_lockout = 1'b0, remote_off = 1'b0, feedback_undervoltage = 1'b0;
    logic thermal_shutdown = 1'b0, supply_start_level = 1'b1;
    wire logic hreadyout_q, hresp_q, irq_q, sense_below_threshold, brownout_compare_out_q;
    wire logic sense_clamp_source_q, line_low_flag_q, pfc_drive_enable_q, ctrl_node_ground_q;
    wire logic hysteresis_sink_q, sense_pulldown_q, latch_clear_q, startup_delay_reset_q;
    wire logic [31:0] hrdata_q;
    int num_errors = 0, check_count = 0, n;
    int dips[2] = '{10, 30};
    logic [31:0] evs[2] = '{32'h1, 32'h5};
    line_brownout_qualifier #(.BLANK_CYCLES(32'h14), .BLANK_MIN_CYCLES(32'ha),
        .WINDOW_CYCLES(32'h14)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout_q), .hreadyout_q, .hresp_q, .hrdata_q, .irq_q,
        .sense_below_threshold, .supply_lockout, .remote_off, .feedback_undervoltage,
        .thermal_shutdown, .supply_start_level, .brownout_compare_out_q, .sense_clamp_source_q,
        .line_low_flag_q, .pfc_drive_enable_q, .ctrl_node_ground_q, .hysteresis_sink_q,
        .sense_pulldown_q, .latch_clear_q, .startup_delay_reset_q);
    sense_divider_model far (.lvl, .sink(hysteresis_sink_q), .pull_low(sense_pulldown_q),
        .below(sense_below_threshold));
    initial begin
        forever #5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tout();
        num_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        print_verdict();
    endtask
    task automatic rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
            if (k > 50) tout();
        end while (hreadyout_q !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata_q;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r, e);
        chk(hresp_q, 1'b0);
    endtask
    task automatic wfl(input logic v);
        n = 0;
        while (line_low_flag_q !== v) begin
            @(posedge hclk);
            n++;
            if (n > 300) tout();
        end
    endtask
    task automatic setoff(input int i, input logic v);
        supply_start_level <= (i != 0) || !v;
        case (i)
            0: supply_lockout <= v;
            1: remote_off <= v;
            2: feedback_undervoltage <= v;
            3: thermal_shutdown <= v;
            default: bus(1'b1, 32'h0, {31'h0, v});
        endcase
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wfl(1'b0);
        rd(32'h4, 32'h2);
        bus(1'b1, 32'hc, 32'hf);
        rd(32'hc, 32'hf);
        rd(32'h10, 32'h0);
        bus(1'b0, 32'h8, 32'h0);
        foreach (dips[i]) begin
            lvl <= 2'h0;
            repeat (dips[i]) @(posedge hclk);
            chk({brownout_compare_out_q, sense_clamp_source_q}, 2'h3);
            lvl <= 2'h2;
            repeat (30) @(posedge hclk);
            chk(line_low_flag_q, 1'b0);
            chk(brownout_compare_out_q, 1'b0);
            chk(irq_q, 1'b1);
            rd(32'h8, evs[i]);
            repeat (2) @(posedge hclk);
            chk(irq_q, 1'b0);
            $display("dip of %0d cycles done", dips[i]);
        end
        lvl <= 2'h0;
        wfl(1'b1);
        chk(n >= 31, 1'b1);
        chk({pfc_drive_enable_q, ctrl_node_ground_q, sense_clamp_source_q, hysteresis_sink_q},
            4'h5);
        rd(32'h8, 32'h3);
        lvl <= 2'h1;
        repeat (40) @(posedge hclk);
        chk(line_low_flag_q, 1'b1);
        lvl <= 2'h2;
        wfl(1'b0);
        rd(32'h8, 32'h8);
        $display("brown-out and recovery done");
        for (int i = 0; i < 5; i++) begin
            setoff(i, 1'b1);
            repeat (3) @(posedge hclk);
            chk({line_low_flag_q, sense_pulldown_q, hysteresis_sink_q}, {2'h3, i != 0});
            setoff(i, 1'b0);
            wfl(1'b0);
            rd(32'h4, 32'h2);
            $display("off source %0d done", i);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
